/* pkg/synth_divider_phase_map.svh */
// register offsets, field positions and reset values of the divider and phase bank
// assumes byte-wide registers addressed by an 8-bit offset
`ifndef SYNTH_DIVIDER_PHASE_MAP_SVH
`define SYNTH_DIVIDER_PHASE_MAP_SVH

`define SDP_ADDR_W 8
`define SDP_DATA_W 8

// register offsets
`define SDP_OFS_INT_DIVIDE_LOW 8'h10
`define SDP_OFS_INT_DIVIDE_HIGH 8'h11
`define SDP_OFS_CAL_PRESCALER_CTRL 8'h12
`define SDP_OFS_PRIMARY_FRACTION_B0 8'h14
`define SDP_OFS_PRIMARY_FRACTION_B1 8'h15
`define SDP_OFS_PRIMARY_FRACTION_B2 8'h16
`define SDP_OFS_FRACTION_SHARED_BYTE 8'h17
`define SDP_OFS_AUX_FRACTION_HIGH 8'h18
`define SDP_OFS_AUX_MODULUS_LOW 8'h19
`define SDP_OFS_AUX_MODULUS_HIGH_PHASE_EN 8'h1a
`define SDP_OFS_PHASE_OFFSET_B0 8'h1b
`define SDP_OFS_PHASE_OFFSET_B1 8'h1c
`define SDP_OFS_PHASE_OFFSET_B2 8'h1d

// field positions
`define SDP_BIT_VCO_SELFCAL_ENABLE 6
`define SDP_BIT_PRESCALER_SEL 5
`define SDP_BIT_PRIMARY_FRACTION_TOP 0
`define SDP_BIT_PHASE_SHIFT_ENABLE 6

// reset values
`define SDP_RST_INT_DIVIDE_LOW 8'h32
`define SDP_RST_INT_DIVIDE_HIGH 8'h00
`define SDP_RST_VCO_SELFCAL_ENABLE 1'h1
`define SDP_RST_PRESCALER_SEL 1'h0
`define SDP_RST_PRIMARY_FRACTION 25'h0000000
`define SDP_RST_AUXILIARY_FRACTION 14'h0000
`define SDP_RST_AUX_MODULUS_LOW 8'he8
`define SDP_RST_AUX_MODULUS_HIGH 6'h03
`define SDP_RST_PHASE_SHIFT_ENABLE 1'h0
`define SDP_RST_PHASE_OFFSET 24'h000000

`endif

/* pkg/synth_divider_phase_pkg.sv */
// types shared by the divider and phase register bank
// assumes nothing beyond a SystemVerilog compiler
package synth_divider_phase_pkg;

    // the four values that move together into the active divider
    typedef struct packed {
        logic [15:0] intDivide;
        logic [24:0] primaryFractionValue;
        logic [13:0] auxiliaryFractionValue;
        logic [13:0] auxiliaryModulusValue;
    } divider_set_s;

    // host-side register access, same clock as the bank
    typedef struct packed {
        logic wrStrobe;
        logic rdStrobe;
        logic [7:0] addr;
        logic [7:0] wrData;
    } reg_access_s;

    // every flip-flop of the bank but the reset synchronizer and the active divider copy
    typedef struct packed {
        divider_set_s staged;
        logic vcoSelfcalEnable;
        logic prescalerSel;
        logic phaseShiftEnable;
        logic [23:0] phaseOffset;
        logic [7:0] rdData;
        logic rdValid;
        logic commitPulse;
    } bank_state_s;

endpackage : synth_divider_phase_pkg

/* rtl/commit_buffer.sv */
// active copy of a double-buffered value, loaded on a commit strobe
// assumes load and loadValue come from logic on the same clock
`timescale 1ns/1ps
module commit_buffer #(
    parameter int WIDTH = 69,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic sysClk,
    input wire logic rstSync_n,
    input wire logic clkEn,
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    output logic [WIDTH-1:0] activeValue
);
    logic [WIDTH-1:0] active_reg;
    logic [WIDTH-1:0] active_next;

    // hold until a commit, frozen while the clock enable is low
    always_comb begin
        active_next = active_reg;
        if (clkEn && load) begin
            active_next = loadValue;
        end
    end

    always_ff @(posedge sysClk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            active_reg <= RESET_VALUE;
        end else begin
            active_reg <= active_next;
        end
    end

    assign activeValue = active_reg;
endmodule : commit_buffer

/* rtl/synth_divider_phase_regs.sv */
// byte register bank for a fractional-N synthesizer: divider words, calibration, prescaler and phase
// assumes the serial control port decodes frames into byte strobes on sys_clk
`timescale 1ns/1ps
`include "synth_divider_phase_map.svh"
module synth_divider_phase_regs (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire synth_divider_phase_pkg::reg_access_s regAccess,
    output logic [7:0] rdData,
    output logic rdValid,
    output synth_divider_phase_pkg::divider_set_s activeDivider,
    output logic commitPulse,
    output logic vcoSelfcalEnable,
    output logic prescalerSel,
    output logic phaseShiftEnable,
    output logic [23:0] phaseOffset
);
    localparam synth_divider_phase_pkg::divider_set_s DIVIDER_RESET = '{
        intDivide: {`SDP_RST_INT_DIVIDE_HIGH, `SDP_RST_INT_DIVIDE_LOW},
        primaryFractionValue: `SDP_RST_PRIMARY_FRACTION,
        auxiliaryFractionValue: `SDP_RST_AUXILIARY_FRACTION,
        auxiliaryModulusValue: {`SDP_RST_AUX_MODULUS_HIGH, `SDP_RST_AUX_MODULUS_LOW}
    };

    logic [1:0] rstPipe_reg;
    logic rstSync_n;
    synth_divider_phase_pkg::bank_state_s state_reg;
    synth_divider_phase_pkg::bank_state_s state_next;
    logic commitLoad;

    // reset enters asynchronously at once but is released through two flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_reg <= 2'h0;
        end else begin
            rstPipe_reg <= {rstPipe_reg[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe_reg[1];

    // a write to the low integer byte is the only commit strobe
    assign commitLoad = regAccess.wrStrobe && (regAccess.addr == `SDP_OFS_INT_DIVIDE_LOW);

    // register writes, readback and pulses; clkEn low freezes everything
    always_comb begin
        state_next = state_reg;
        if (clkEn) begin
            state_next.rdValid = 1'b0;
            state_next.commitPulse = 1'b0;
            if (regAccess.wrStrobe) begin
                case (regAccess.addr)
                    `SDP_OFS_INT_DIVIDE_LOW: begin
                        state_next.staged.intDivide[7:0] = regAccess.wrData;
                        state_next.commitPulse = 1'b1;
                    end
                    `SDP_OFS_INT_DIVIDE_HIGH: begin
                        state_next.staged.intDivide[15:8] = regAccess.wrData;
                    end
                    `SDP_OFS_CAL_PRESCALER_CTRL: begin
                        // bits 7 and 4:0 are reserved and dropped
                        state_next.vcoSelfcalEnable = regAccess.wrData[`SDP_BIT_VCO_SELFCAL_ENABLE];
                        state_next.prescalerSel = regAccess.wrData[`SDP_BIT_PRESCALER_SEL];
                    end
                    `SDP_OFS_PRIMARY_FRACTION_B0: begin
                        state_next.staged.primaryFractionValue[7:0] = regAccess.wrData;
                    end
                    `SDP_OFS_PRIMARY_FRACTION_B1: begin
                        state_next.staged.primaryFractionValue[15:8] = regAccess.wrData;
                    end
                    `SDP_OFS_PRIMARY_FRACTION_B2: begin
                        state_next.staged.primaryFractionValue[23:16] = regAccess.wrData;
                    end
                    `SDP_OFS_FRACTION_SHARED_BYTE: begin
                        state_next.staged.primaryFractionValue[24] =
                            regAccess.wrData[`SDP_BIT_PRIMARY_FRACTION_TOP];
                        state_next.staged.auxiliaryFractionValue[6:0] = regAccess.wrData[7:1];
                    end
                    `SDP_OFS_AUX_FRACTION_HIGH: begin
                        state_next.staged.auxiliaryFractionValue[13:7] = regAccess.wrData[6:0];
                    end
                    `SDP_OFS_AUX_MODULUS_LOW: begin
                        state_next.staged.auxiliaryModulusValue[7:0] = regAccess.wrData;
                    end
                    `SDP_OFS_AUX_MODULUS_HIGH_PHASE_EN: begin
                        state_next.staged.auxiliaryModulusValue[13:8] = regAccess.wrData[5:0];
                        state_next.phaseShiftEnable = regAccess.wrData[`SDP_BIT_PHASE_SHIFT_ENABLE];
                    end
                    `SDP_OFS_PHASE_OFFSET_B0: begin
                        state_next.phaseOffset[7:0] = regAccess.wrData;
                    end
                    `SDP_OFS_PHASE_OFFSET_B1: begin
                        state_next.phaseOffset[15:8] = regAccess.wrData;
                    end
                    `SDP_OFS_PHASE_OFFSET_B2: begin
                        state_next.phaseOffset[23:16] = regAccess.wrData;
                    end
                    default: begin
                        // unmapped offsets and the gap at 0x13 swallow writes
                    end
                endcase
            end
            // readback shows what software wrote, which may run ahead of the active divider
            if (regAccess.rdStrobe) begin
                state_next.rdValid = 1'b1;
                case (regAccess.addr)
                    `SDP_OFS_INT_DIVIDE_LOW: state_next.rdData = state_reg.staged.intDivide[7:0];
                    `SDP_OFS_INT_DIVIDE_HIGH: state_next.rdData = state_reg.staged.intDivide[15:8];
                    `SDP_OFS_CAL_PRESCALER_CTRL: begin
                        state_next.rdData = {1'b0, state_reg.vcoSelfcalEnable, state_reg.prescalerSel, 5'h00};
                    end
                    `SDP_OFS_PRIMARY_FRACTION_B0: state_next.rdData = state_reg.staged.primaryFractionValue[7:0];
                    `SDP_OFS_PRIMARY_FRACTION_B1: state_next.rdData = state_reg.staged.primaryFractionValue[15:8];
                    `SDP_OFS_PRIMARY_FRACTION_B2: state_next.rdData = state_reg.staged.primaryFractionValue[23:16];
                    `SDP_OFS_FRACTION_SHARED_BYTE: begin
                        state_next.rdData = {state_reg.staged.auxiliaryFractionValue[6:0],
                                             state_reg.staged.primaryFractionValue[24]};
                    end
                    `SDP_OFS_AUX_FRACTION_HIGH: begin
                        state_next.rdData = {1'b0, state_reg.staged.auxiliaryFractionValue[13:7]};
                    end
                    `SDP_OFS_AUX_MODULUS_LOW: state_next.rdData = state_reg.staged.auxiliaryModulusValue[7:0];
                    `SDP_OFS_AUX_MODULUS_HIGH_PHASE_EN: begin
                        state_next.rdData = {1'b0, state_reg.phaseShiftEnable,
                                             state_reg.staged.auxiliaryModulusValue[13:8]};
                    end
                    `SDP_OFS_PHASE_OFFSET_B0: state_next.rdData = state_reg.phaseOffset[7:0];
                    `SDP_OFS_PHASE_OFFSET_B1: state_next.rdData = state_reg.phaseOffset[15:8];
                    `SDP_OFS_PHASE_OFFSET_B2: state_next.rdData = state_reg.phaseOffset[23:16];
                    default: state_next.rdData = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_reg.staged <= DIVIDER_RESET;
            state_reg.vcoSelfcalEnable <= `SDP_RST_VCO_SELFCAL_ENABLE;
            state_reg.prescalerSel <= `SDP_RST_PRESCALER_SEL;
            state_reg.phaseShiftEnable <= `SDP_RST_PHASE_SHIFT_ENABLE;
            state_reg.phaseOffset <= `SDP_RST_PHASE_OFFSET;
            state_reg.rdData <= 8'h00;
            state_reg.rdValid <= 1'b0;
            state_reg.commitPulse <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // the active copy takes the whole staged set, including the new low byte, in one edge;
    // a host that leaves the low byte for last gets a consistent update
    commit_buffer #(
        .WIDTH($bits(synth_divider_phase_pkg::divider_set_s)),
        .RESET_VALUE(DIVIDER_RESET)
    ) activeDivider_u (
        .sysClk(sys_clk),
        .rstSync_n(rstSync_n),
        .clkEn(clkEn),
        .load(commitLoad),
        .loadValue(state_next.staged),
        .activeValue(activeDivider)
    );

    assign rdData = state_reg.rdData;
    assign rdValid = state_reg.rdValid;
    assign commitPulse = state_reg.commitPulse;
    assign vcoSelfcalEnable = state_reg.vcoSelfcalEnable;
    assign prescalerSel = state_reg.prescalerSel; // 0 is 4/5, 1 is 8/9
    // phase step in degrees = phaseOffset / 16777216 * 360, applied by the analogue side
    assign phaseShiftEnable = state_reg.phaseShiftEnable;
    assign phaseOffset = state_reg.phaseOffset;
endmodule : synth_divider_phase_regs

/* testbench/host_port_model.sv */
// host controller model driving the bank's byte strobe port
// assumes the bank samples requests on the rising edge of sys_clk
`timescale 1ns/1ps
module host_port_model (
    input wire logic sys_clk,
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    output synth_divider_phase_pkg::reg_access_s regAccess
);
    initial regAccess = '0;
    // released lines show the inverse so a stale value never looks like a request
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAccess <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        regAccess <= '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
    // read data is taken once the taking edge's updates have landed
    task automatic rd(input logic [7:0] a, output logic v, output logic [7:0] d);
        @(posedge sys_clk);
        regAccess <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk);
        regAccess <= '{1'b0, 1'b0, ~a, 8'hff};
        #1;
        v = rdValid;
        d = rdData;
    endtask : rd
    // low integer byte goes last so the whole staged set moves at once
    task automatic commit(input logic [7:0] d);
        wr(8'h10, d);
    endtask : commit
endmodule : host_port_model

/* testbench/synth_divider_phase_regs_properties.sv */
// concurrent checks on the divider and phase register bank
// assumes it is bound to the bank and sees only its ports
`timescale 1ns/1ps
module synth_divider_phase_regs_properties (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire synth_divider_phase_pkg::reg_access_s regAccess,
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    input wire synth_divider_phase_pkg::divider_set_s activeDivider,
    input wire logic commitPulse,
    input wire logic vcoSelfcalEnable,
    input wire logic prescalerSel,
    input wire logic phaseShiftEnable,
    input wire logic [23:0] phaseOffset
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // taken requests as plain levels, so that $past can look back at them
    logic lowWrite;
    logic ctrlRead;
    assign lowWrite = clkEn && regAccess.wrStrobe && regAccess.addr == 8'h10;
    assign ctrlRead = clkEn && regAccess.rdStrobe && regAccess.addr == 8'h12;
    // a request taken by the bank
    sequence wrTaken(a);
        clkEn && regAccess.wrStrobe && regAccess.addr == a;
    endsequence
    sequence rdAlone;
        clkEn && regAccess.rdStrobe ##1 clkEn && !regAccess.rdStrobe;
    endsequence
    a_read_pulse_once: assert property (rdAlone |-> rdValid ##1 !rdValid)
        else $error("read answer is not a one cycle pulse");
    a_reserved_read_zero: assert property ($past(ctrlRead) |-> rdValid && (rdData & 8'h9f) == 8'h00)
        else $error("reserved control bits read non zero");
    a_commit_on_low: assert property (wrTaken(8'h10) |=> commitPulse)
        else $error("low integer write gave no commit");
    // a pulse held by a frozen clock enable is not a new commit
    a_commit_has_cause: assert property (commitPulse && $past(clkEn) |-> $past(lowWrite))
        else $error("commit without low integer write");
    a_active_held: assert property (!commitPulse |-> $stable(activeDivider))
        else $error("active divider moved without commit");
    a_int_low_lands: assert property (wrTaken(8'h10) |=>
        activeDivider.intDivide[7:0] == $past(regAccess.wrData)) else $error("committed integer low byte wrong");
    a_selfcal_follows: assert property (wrTaken(8'h12) |=> vcoSelfcalEnable == $past(regAccess.wrData[6]))
        else $error("self calibration enable wrong");
    a_prescaler_follows: assert property (wrTaken(8'h12) |=> prescalerSel == $past(regAccess.wrData[5]))
        else $error("prescaler select wrong");
    a_phase_en_follows: assert property (wrTaken(8'h1a) |=> phaseShiftEnable == $past(regAccess.wrData[6]))
        else $error("phase shift enable wrong");
    a_phase_top_byte: assert property (wrTaken(8'h1d) |=> phaseOffset[23:16] == $past(regAccess.wrData))
        else $error("phase offset top byte wrong");
endmodule : synth_divider_phase_regs_properties

bind synth_divider_phase_regs synth_divider_phase_regs_properties chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .clkEn(clkEn), .regAccess(regAccess), .rdData(rdData), .rdValid(rdValid), .activeDivider(activeDivider),
    .commitPulse(commitPulse), .vcoSelfcalEnable(vcoSelfcalEnable), .prescalerSel(prescalerSel),
    .phaseShiftEnable(phaseShiftEnable), .phaseOffset(phaseOffset));

/* testbench/tb_top.sv */
// self-checking bench for the divider and phase register bank
// assumes the checker is bound to the bank and the host model drives its port
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    synth_divider_phase_pkg::reg_access_s regAccess;
    synth_divider_phase_pkg::divider_set_s activeDivider, actExp;
    logic [7:0] rdData, d;
    logic rdValid, v, commitPulse, vcoSelfcalEnable, prescalerSel, phaseShiftEnable;
    logic [23:0] phaseOffset;
    logic [7:0] st [0:31];
    int numErrors = 0;
    int samplesChecked = 0;

    always #5 sys_clk = ~sys_clk;

    host_port_model host (.sys_clk(sys_clk), .rdData(rdData), .rdValid(rdValid), .regAccess(regAccess));
    synth_divider_phase_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .regAccess(regAccess),
        .rdData(rdData), .rdValid(rdValid), .activeDivider(activeDivider), .commitPulse(commitPulse),
        .vcoSelfcalEnable(vcoSelfcalEnable), .prescalerSel(prescalerSel),
        .phaseShiftEnable(phaseShiftEnable), .phaseOffset(phaseOffset));

    // writable bits of each offset; unmapped offsets keep nothing
    function automatic logic [7:0] keepMask(input logic [7:0] a);
        if (a == 8'h12) return 8'h60;
        if (a == 8'h18 || a == 8'h1a) return 8'h7f;
        return (a inside {[8'h10:8'h1d]} && a != 8'h13) ? 8'hff : 8'h00;
    endfunction : keepMask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            numErrors++;
            $display("MISMATCH %s exp %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finishTest;
        if (numErrors == 0 && samplesChecked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finishTest

    // every offset around the bank, unmapped neighbours included
    task automatic readAll;
        for (int a = 8'h0e; a <= 8'h1f; a++) begin
            host.rd(8'(a), v, d);
            check("rdValid", v, 1'b1);
            check($sformatf("reg %h", a), d, st[a]);
        end
    endtask : readAll

    // outputs checked after the edge's updates have landed
    task automatic checkOutputs;
        #1;
        check("intDivide", activeDivider.intDivide, actExp.intDivide);
        check("primary", activeDivider.primaryFractionValue, actExp.primaryFractionValue);
        check("auxFraction", activeDivider.auxiliaryFractionValue, actExp.auxiliaryFractionValue);
        check("auxModulus", activeDivider.auxiliaryModulusValue, actExp.auxiliaryModulusValue);
        check("selfcal", vcoSelfcalEnable, st[18][6]);
        check("prescaler", prescalerSel, st[18][5]);
        check("phaseEn", phaseShiftEnable, st[26][6]);
        check("phaseOffset", phaseOffset, {st[29], st[28], st[27]});
    endtask : checkOutputs

    // reset values, then two passes of inverted patterns so every control bit takes both values
    initial begin
        foreach (st[i]) st[i] = 8'h00;
        st[16] = 8'h32;
        st[18] = 8'h40;
        st[25] = 8'he8;
        st[26] = 8'h03;
        actExp = {16'h0032, 25'h0000000, 14'h0000, 14'h03e8};
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        readAll;
        checkOutputs;
        for (int p = 0; p < 2; p++) begin
            for (int a = 8'h0e; a <= 8'h1f; a++) begin
                if (a != 8'h10) begin
                    d = {a[3:0], ~a[3:0]} ^ {8{p[0]}};
                    host.wr(8'(a), d);
                    st[a] = d & keepMask(8'(a));
                end
            end
            readAll;
            checkOutputs;
            check("commitPulse", commitPulse, 1'b0);
            d = 8'h5a ^ {8{p[0]}};
            host.commit(d);
            st[16] = d;
            actExp = {st[17], st[16], st[23][0], st[22], st[21], st[20],
                st[24][6:0], st[23][7:1], st[26][5:0], st[25]};
            checkOutputs;
            check("commitPulse", commitPulse, 1'b1);
        end
        // clock enable low: a write and a commit are not taken, nothing moves
        @(posedge sys_clk);
        clkEn <= 1'b0;
        host.wr(8'h1d, 8'h77);
        host.commit(8'h11);
        checkOutputs;
        check("frozenPulse", commitPulse, 1'b0);
        @(posedge sys_clk);
        clkEn <= 1'b1;
        readAll;
        finishTest;
    end

    // a hang is cut short well past the few hundred cycles the passes need
    initial begin
        #200000;
        numErrors++;
        finishTest;
    end
endmodule : tb_top
